// [design/smx_pkg.sv]
package smx_pkg;
    // register indices
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SIM_CTRL = 8'h08;
    localparam logic [7:0] REG_BATTERY_SENSE_DEBOUNCED = 8'h0a;
    localparam logic [7:0] REG_SDN_DEB = 8'h0b;
    localparam logic [7:0] REG_CLK_CTRL = 8'h0d;
    localparam logic [7:0] REG_DEV_CTRL = 8'h0e;
    localparam logic [7:0] REG_GP = 8'h15;
    // reset values and write masks
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_DEB = 8'h04;
    localparam logic [7:0] GP_MASK = 8'h03;
    localparam logic [7:0] CLK_CTRL_MASK = 8'hff;
    // device control bits
    localparam int DC_OE_EN = 0;
    localparam int DC_OE_INV = 1;
    localparam int DC_BSI_IRQ = 2;
    localparam int DC_BSI_LVL = 3;
    localparam int DC_BSI_NOPD = 4;
    localparam int DC_SDN_IRQ = 5;
    localparam int DC_SDN_LVL = 6;
    localparam int DC_SDN_NOPD = 7;
    // status bits
    localparam int ST_SDN = 1;
    localparam int ST_BSI = 3;
    // general purpose bits
    localparam int GP_PU_OFF = 0;
    localparam int GP_PD_ON = 1;
    // clock control bit
    localparam int CC_EXT = 7;
    // slot control fields
    localparam int S1_REG = 0;
    localparam int S1_VSEL = 1;
    localparam int S1_ST = 2;
    localparam int S2_REG = 4;
    localparam int S2_VSEL = 5;
    localparam int S2_ST = 6;
    localparam logic [1:0] SLOT_OFF = 2'h0;
    localparam logic [3:0] SLOT_NIBBLE_OFF = 4'h0;
    // slave address, upper six bits
    localparam logic [5:0] ADDR_HI = 6'h1e;
    // timing
    localparam int CLK_HZ = 125000000;
    localparam int INT_CLK_HZ = 32768;
    localparam logic [11:0] INT_DIV_CYCLES = 12'(CLK_HZ / INT_CLK_HZ - 1);
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam logic [3:0] BIT_LAST = 4'h7;

    typedef enum logic [3:0] {
        I2C_IDLE = 4'b0000,
        I2C_ADDR = 4'b0001,
        I2C_ACK_ADDR = 4'b0010,
        I2C_REG = 4'b0011,
        I2C_ACK_REG = 4'b0100,
        I2C_WDATA = 4'b0101,
        I2C_ACK_W = 4'b0110,
        I2C_RDATA = 4'b0111,
        I2C_RACK = 4'b1000
    } smx_i2c_t;

    typedef struct packed {
        logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
        logic oe_s1, oe_s2, bsi_s1, bsi_s2, sdn_s1, sdn_s2, irq_s1, irq_s2;
        logic tg_s1, tg_s2, tg_d;
        logic [1:0] strap_cnt;
        logic strap_done;
        logic addr_lsb;
        logic [11:0] div_cnt;
        smx_i2c_t i2c;
        logic [3:0] bitc;
        logic [7:0] sh;
        logic rw;
        logic mack;
        logic sda_low;
        logic [7:0] idx;
        logic [7:0] sim_ctrl, status, bsi_reload, sdn_reload, clk_ctrl, dev_ctrl, gp;
        logic [7:0] bsi_cnt, sdn_cnt;
        logic battery_sense_debounced, sdn_deb;
        logic auto_dir, card_to_host, irq_drive;
    } smx_state_t;
endpackage

// [design/smx_device_control.sv]
`timescale 1ns/1ps
// Function
// - device control bit 0 clear: ignore direction pin, auto-direction; set: pin steers.
// - bit 1 clear: pin low host-to-card, high card-to-host; set inverts this.
// - bit 2 set: battery removal raises interrupt pin and status bit 3.
// - bit 4 clear: battery absence powers down both slots; set: no power-down.
// - bit 5 set: shutdown detection raises interrupt pin and status bit 1.
// - bit 6 selects shutdown input active level: 0 low, 1 high.
// - bit 7 clear: shutdown detection powers down slot 2 only; set: none.
// - general purpose bit 0: pull-up on when 0; bit 1: pull-down on when 1.
// - general purpose bits 7:2 accept writes and read zero; host writes zero.
// - slave address is 011110 plus interrupt pin level caught four clock cycles after reset release.
// - reset restores defaults, deactivates cards, selects no slot, engages slot pull-downs.
// - timing runs from internal 32 kHz until clock source bit selects external.
// - reset clears pending interrupts; pin released and status bits read clear.
// - reset loads both debounce count registers with four.
// - reset selects 1.8V, disables both regulators, pulls slot signals low.
// - slot state 11 active, 01 isolated latched, 00 off or isolated by regulator.
// - clock control bit 7 picks internal 32 kHz when 0, external when 1.
// - battery interrupt fires on debounced battery sense rising with enable set.
module smx_device_control import smx_pkg::*; (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic ext_clk_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic irq_in,
    output logic irq_out,
    output logic irq_oe_out,
    input wire logic host_dir_in,
    input wire logic battery_sense_input_in,
    input wire logic shutdown_input_in,
    output logic host_io_auto_dir_out,
    output logic host_io_card_to_host_out,
    output logic slot1_reg_en_out,
    output logic slot1_volt_sel_out,
    output logic [1:0] slot1_state_out,
    output logic slot1_pulldown_out,
    output logic slot2_reg_en_out,
    output logic slot2_volt_sel_out,
    output logic [1:0] slot2_state_out,
    output logic slot2_pulldown_out,
    output logic shutdown_input_pullup_en_out,
    output logic shutdown_input_pulldown_en_out,
    output logic bsi_level_sel_out,
    output logic clk_src_ext_out
);
    smx_state_t st_r;
    smx_state_t st_nxt;
    logic ext_tog_r;

    // external 32 kHz domain: one toggle per rising edge, carried over as an event
    always_ff @(posedge ext_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ext_tog_r <= 1'b0;
        end else begin
            ext_tog_r <= ~ext_tog_r;
        end
    end

    function automatic logic [8:0] deb_step(input logic raw, input logic [7:0] reload,
                                           input logic [7:0] cnt, input logic deb, input logic tick);
        logic [8:0] r;
        r = {deb, cnt};
        if (!raw) begin
            r = {1'b0, reload};
        end else if (tick) begin
            if (cnt == RST_ZERO) begin
                r = {1'b1, cnt};
            end else begin
                r = {deb, cnt - 8'h01};
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] rd_reg(input smx_state_t s, input logic [7:0] a);
        logic [7:0] d;
        d = RST_ZERO;
        case (a)
            REG_STATUS: d = s.status;
            REG_SIM_CTRL: d = s.sim_ctrl;
            REG_BATTERY_SENSE_DEBOUNCED: d = s.bsi_reload;
            REG_SDN_DEB: d = s.sdn_reload;
            REG_CLK_CTRL: d = s.clk_ctrl;
            REG_DEV_CTRL: d = s.dev_ctrl;
            REG_GP: d = s.gp & GP_MASK;
            default: d = RST_ZERO;
        endcase
        return d;
    endfunction

    logic tick;
    logic scl_rise, scl_fall, start_c, stop_c;
    logic [8:0] bsi_step, sdn_step;
    logic bsi_rise, sdn_rise;

    always_comb begin
        st_nxt = st_r;
        // synchronisers
        st_nxt.scl_s1 = scl_in;
        st_nxt.scl_s2 = st_r.scl_s1;
        st_nxt.scl_d = st_r.scl_s2;
        st_nxt.sda_s1 = sda_in;
        st_nxt.sda_s2 = st_r.sda_s1;
        st_nxt.sda_d = st_r.sda_s2;
        st_nxt.oe_s1 = host_dir_in;
        st_nxt.oe_s2 = st_r.oe_s1;
        st_nxt.bsi_s1 = battery_sense_input_in;
        st_nxt.bsi_s2 = st_r.bsi_s1;
        st_nxt.sdn_s1 = shutdown_input_in;
        st_nxt.sdn_s2 = st_r.sdn_s1;
        st_nxt.irq_s1 = irq_in;
        st_nxt.irq_s2 = st_r.irq_s1;
        st_nxt.tg_s1 = ext_tog_r;
        st_nxt.tg_s2 = st_r.tg_s1;
        st_nxt.tg_d = st_r.tg_s2;
        // address strap caught after release
        if (!st_r.strap_done) begin
            if (st_r.strap_cnt == STRAP_WAIT) begin
                st_nxt.strap_done = 1'b1;
                st_nxt.addr_lsb = st_r.irq_s2;
            end else begin
                st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
            end
        end
        // 32 kHz timing tick
        st_nxt.div_cnt = (st_r.div_cnt == 12'h000) ? INT_DIV_CYCLES : st_r.div_cnt - 12'h001;
        tick = st_r.clk_ctrl[CC_EXT] ? (st_r.tg_s2 ^ st_r.tg_d) : (st_r.div_cnt == 12'h000);
        // debounce
        bsi_step = deb_step(st_r.bsi_s2, st_r.bsi_reload, st_r.bsi_cnt, st_r.battery_sense_debounced, tick);
        sdn_step = deb_step(st_r.sdn_s2 == st_r.dev_ctrl[DC_SDN_LVL], st_r.sdn_reload,
                            st_r.sdn_cnt, st_r.sdn_deb, tick);
        {st_nxt.battery_sense_debounced, st_nxt.bsi_cnt} = bsi_step;
        {st_nxt.sdn_deb, st_nxt.sdn_cnt} = sdn_step;
        bsi_rise = bsi_step[8] & ~st_r.battery_sense_debounced;
        sdn_rise = sdn_step[8] & ~st_r.sdn_deb;
        // i2c slave
        scl_rise = st_r.scl_s2 & ~st_r.scl_d;
        scl_fall = ~st_r.scl_s2 & st_r.scl_d;
        start_c = st_r.scl_s2 & st_r.scl_d & st_r.sda_d & ~st_r.sda_s2;
        stop_c = st_r.scl_s2 & st_r.scl_d & ~st_r.sda_d & st_r.sda_s2;
        if (start_c) begin
            st_nxt.i2c = I2C_ADDR;
            st_nxt.bitc = 4'h0;
            st_nxt.sda_low = 1'b0;
        end else if (stop_c) begin
            st_nxt.i2c = I2C_IDLE;
            st_nxt.sda_low = 1'b0;
        end else if (scl_rise) begin
            case (st_r.i2c)
                I2C_ADDR, I2C_REG, I2C_WDATA: begin
                    st_nxt.sh = {st_r.sh[6:0], st_r.sda_s2};
                    st_nxt.bitc = st_r.bitc + 4'h1;
                end
                I2C_RACK: st_nxt.mack = ~st_r.sda_s2;
                default: st_nxt.i2c = st_r.i2c;
            endcase
        end else if (scl_fall) begin
            case (st_r.i2c)
                I2C_ADDR: begin
                    if (st_r.bitc == BITS_BYTE) begin
                        if (st_r.sh[7:1] == {ADDR_HI, st_r.addr_lsb}) begin
                            st_nxt.rw = st_r.sh[0];
                            st_nxt.sda_low = 1'b1;
                            st_nxt.i2c = I2C_ACK_ADDR;
                        end else begin
                            st_nxt.i2c = I2C_IDLE;
                        end
                    end
                end
                I2C_ACK_ADDR, I2C_RACK: begin
                    st_nxt.bitc = 4'h0;
                    if (st_r.i2c == I2C_RACK && !st_r.mack) begin
                        st_nxt.sda_low = 1'b0;
                        st_nxt.i2c = I2C_IDLE;
                    end else if (st_r.rw) begin
                        st_nxt.sh = rd_reg(st_r, st_r.idx);
                        st_nxt.sda_low = ~st_nxt.sh[7];
                        st_nxt.idx = st_r.idx + 8'h01;
                        st_nxt.i2c = I2C_RDATA;
                        if (st_r.idx == REG_STATUS) begin
                            st_nxt.status = RST_ZERO;
                        end
                    end else begin
                        st_nxt.sda_low = 1'b0;
                        st_nxt.i2c = I2C_REG;
                    end
                end
                I2C_REG: begin
                    if (st_r.bitc == BITS_BYTE) begin
                        st_nxt.idx = st_r.sh;
                        st_nxt.sda_low = 1'b1;
                        st_nxt.i2c = I2C_ACK_REG;
                    end
                end
                I2C_ACK_REG, I2C_ACK_W: begin
                    st_nxt.sda_low = 1'b0;
                    st_nxt.bitc = 4'h0;
                    st_nxt.i2c = I2C_WDATA;
                end
                I2C_WDATA: begin
                    if (st_r.bitc == BITS_BYTE) begin
                        case (st_r.idx)
                            REG_SIM_CTRL: st_nxt.sim_ctrl = st_r.sh;
                            REG_BATTERY_SENSE_DEBOUNCED: st_nxt.bsi_reload = st_r.sh;
                            REG_SDN_DEB: st_nxt.sdn_reload = st_r.sh;
                            REG_CLK_CTRL: st_nxt.clk_ctrl = st_r.sh & CLK_CTRL_MASK;
                            REG_DEV_CTRL: st_nxt.dev_ctrl = st_r.sh;
                            REG_GP: st_nxt.gp = st_r.sh & GP_MASK;
                            default: st_nxt.gp = st_nxt.gp;
                        endcase
                        st_nxt.idx = st_r.idx + 8'h01;
                        st_nxt.sda_low = 1'b1;
                        st_nxt.i2c = I2C_ACK_W;
                    end
                end
                I2C_RDATA: begin
                    if (st_r.bitc == BIT_LAST) begin
                        st_nxt.sda_low = 1'b0;
                        st_nxt.i2c = I2C_RACK;
                    end else begin
                        st_nxt.bitc = st_r.bitc + 4'h1;
                        st_nxt.sh = {st_r.sh[6:0], 1'b0};
                        st_nxt.sda_low = ~st_r.sh[6];
                    end
                end
                default: st_nxt.i2c = st_r.i2c;
            endcase
        end
        // events: set wins over the read clear above
        if (bsi_rise && st_r.dev_ctrl[DC_BSI_IRQ]) begin
            st_nxt.status[ST_BSI] = 1'b1;
        end
        if (sdn_rise && st_r.dev_ctrl[DC_SDN_IRQ]) begin
            st_nxt.status[ST_SDN] = 1'b1;
        end
        // automatic power-down overrides a same-cycle write
        if (bsi_rise && !st_r.dev_ctrl[DC_BSI_NOPD]) begin
            st_nxt.sim_ctrl = RST_ZERO;
        end
        if (sdn_rise && !st_r.dev_ctrl[DC_SDN_NOPD]) begin
            st_nxt.sim_ctrl[S2_ST+1:S2_REG] = SLOT_NIBBLE_OFF;
        end
        // direction control
        st_nxt.auto_dir = ~st_r.dev_ctrl[DC_OE_EN];
        st_nxt.card_to_host = st_r.dev_ctrl[DC_OE_EN] & (st_r.oe_s2 ^ st_r.dev_ctrl[DC_OE_INV]);
        st_nxt.irq_drive = st_r.strap_done & (st_nxt.status[ST_BSI] | st_nxt.status[ST_SDN]);
    end

    // reset: all registers default, slots off at 1.8V, no slot selected
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r <= '0;
            st_r.bsi_reload <= RST_DEB;
            st_r.sdn_reload <= RST_DEB;
            st_r.bsi_cnt <= RST_DEB;
            st_r.sdn_cnt <= RST_DEB;
            st_r.div_cnt <= INT_DIV_CYCLES;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = st_r.sda_low;
    assign irq_out = 1'b0;
    assign irq_oe_out = st_r.irq_drive;
    assign host_io_auto_dir_out = st_r.auto_dir;
    assign host_io_card_to_host_out = st_r.card_to_host;
    assign slot1_reg_en_out = st_r.sim_ctrl[S1_REG];
    assign slot1_volt_sel_out = st_r.sim_ctrl[S1_VSEL];
    assign slot1_state_out = st_r.sim_ctrl[S1_ST+1:S1_ST];
    assign slot1_pulldown_out = (st_r.sim_ctrl[S1_ST+1:S1_ST] == SLOT_OFF) & ~st_r.sim_ctrl[S1_REG];
    assign slot2_reg_en_out = st_r.sim_ctrl[S2_REG];
    assign slot2_volt_sel_out = st_r.sim_ctrl[S2_VSEL];
    assign slot2_state_out = st_r.sim_ctrl[S2_ST+1:S2_ST];
    assign slot2_pulldown_out = (st_r.sim_ctrl[S2_ST+1:S2_ST] == SLOT_OFF) & ~st_r.sim_ctrl[S2_REG];
    assign shutdown_input_pullup_en_out = ~st_r.gp[GP_PU_OFF];
    assign shutdown_input_pulldown_en_out = st_r.gp[GP_PD_ON];
    assign bsi_level_sel_out = st_r.dev_ctrl[DC_BSI_LVL];
    assign clk_src_ext_out = st_r.clk_ctrl[CC_EXT];

    // checks
    sequence s_bsi_rise;
        $rose(st_r.battery_sense_debounced);
    endsequence
    sequence s_sdn_rise;
        $rose(st_r.sdn_deb);
    endsequence

    a_dir_map: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (st_r.dev_ctrl[DC_OE_EN] && !st_r.dev_ctrl[DC_OE_INV] && st_r.oe_s2) |=> host_io_card_to_host_out)
        else $error("direction pin mapping wrong");
    a_dir_auto: assert property (@(posedge clock_in) disable iff (!resetn_in)
        !st_r.dev_ctrl[DC_OE_EN] |=> (host_io_auto_dir_out && !host_io_card_to_host_out))
        else $error("direction pin not ignored");
    a_bsi_irq_set: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (s_bsi_rise and $past(st_r.dev_ctrl[DC_BSI_IRQ])) |-> st_r.status[ST_BSI] ##1 irq_oe_out)
        else $error("battery interrupt missing");
    a_bsi_irq_off: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (!st_r.dev_ctrl[DC_BSI_IRQ] && !st_r.status[ST_BSI]) |=> !st_r.status[ST_BSI])
        else $error("battery interrupt while disabled");
    a_bsi_pwrdn: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (s_bsi_rise and $past(!st_r.dev_ctrl[DC_BSI_NOPD])) |-> (st_r.sim_ctrl == RST_ZERO))
        else $error("battery power-down missing");
    a_sdn_irq_set: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (s_sdn_rise and $past(st_r.dev_ctrl[DC_SDN_IRQ])) |-> st_r.status[ST_SDN])
        else $error("shutdown interrupt missing");
    a_sdn_pwrdn: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (s_sdn_rise and $past(!st_r.dev_ctrl[DC_SDN_NOPD])) |->
        (st_r.sim_ctrl[S2_ST+1:S2_REG] == SLOT_NIBBLE_OFF && st_r.sim_ctrl[S1_ST+1:S1_REG] ==
         $past(st_r.sim_ctrl[S1_ST+1:S1_REG])))
        else $error("shutdown power-down wrong");
    a_gp_reserved: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (st_r.gp & ~GP_MASK) == RST_ZERO)
        else $error("reserved bits not zero");
    a_irq_pin: assert property (@(posedge clock_in) disable iff (!resetn_in)
        (st_r.strap_done && st_r.status[ST_BSI]) |-> ##[0:1] irq_oe_out)
        else $error("interrupt pin not driven");
endmodule

// [tb/smx_host_model.sv]
`timescale 1ns/1ps
// baseband side: i2c master, sda open drain with pull-up, scl driven push-pull
module smx_host_model (
    input wire logic clock_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    localparam logic [7:0] ADDR_W = 8'h78;
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // one quarter of a bit is 7 clocks, so each scl phase lasts 112 ns
    task automatic q(input int n);
        repeat (n * 7) @(posedge clock_in);
    endtask
    task automatic put_bit(input logic b);
        sda_low_out <= ~b;
        q(1);
        scl_out <= 1'b1;
        q(2);
        scl_out <= 1'b0;
        q(1);
    endtask
    task automatic get_bit(output logic b);
        sda_low_out <= 1'b0;
        q(1);
        scl_out <= 1'b1;
        q(1);
        b = sda_in;
        q(1);
        scl_out <= 1'b0;
        q(1);
    endtask
    task automatic send(input logic [7:0] v, output logic ok);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(v[i]);
        get_bit(a);
        ok = ~a;
    endtask
    task automatic start(input logic rep);
        if (rep) begin
            sda_low_out <= 1'b0;
            q(1);
            scl_out <= 1'b1;
            q(1);
        end
        sda_low_out <= 1'b1;
        q(2);
        scl_out <= 1'b0;
        q(1);
    endtask
    task automatic stop();
        sda_low_out <= 1'b1;
        q(1);
        scl_out <= 1'b1;
        q(2);
        sda_low_out <= 1'b0;
        q(2);
    endtask
    // index byte first, then data; address byte given so a foreign one can be tried
    task automatic write_reg(input logic [7:0] adr, input logic [7:0] idx, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start(1'b0);
        send(adr, a0);
        send(idx, a1);
        send(d, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    // index write, repeated start, one byte read, nack then stop
    task automatic read_reg(input logic [7:0] idx, output logic [7:0] d);
        logic a;
        start(1'b0);
        send(ADDR_W, a);
        send(idx, a);
        start(1'b1);
        send(ADDR_W | 8'h01, a);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(1'b1);
        stop();
    endtask
endmodule

// [tb/smx_device_control_tb.sv]
`timescale 1ns/1ps
module smx_device_control_tb import smx_pkg::*; ;
    logic clock_in = 1'b0, ext_clk = 1'b0, resetn_in = 1'b0, strap_low = 1'b1;
    logic host_dir = 1'b0, batt = 1'b0, shut = 1'b1, scl, sda_low, sda_o, sda_oe, irq_o, irq_oe;
    logic auto_dir, c2h, s1_reg, s1_volt, s1_pd, s2_reg, s2_volt, s2_pd, pu, pd, thresh, clk_ext;
    logic [1:0] s1_st, s2_st;
    int errors = 0, num_checks = 0, cycles = 0;
    logic [7:0] ri [7] = '{REG_STATUS, REG_SIM_CTRL, REG_BATTERY_SENSE_DEBOUNCED, REG_SDN_DEB, REG_CLK_CTRL, REG_DEV_CTRL, REG_GP};
    logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h00, 8'h00, 8'h00};
    wire sda_w = (sda_oe ? sda_o : 1'b1) & ~sda_low;
    wire irq_w = (irq_oe ? irq_o : 1'b1) & ~strap_low;
    always #4 clock_in = ~clock_in;
    always #7.5 ext_clk = ~ext_clk;
    smx_device_control smx_device_control_i (.clock_in(clock_in), .resetn_in(resetn_in), .ext_clk_in(ext_clk),
        .scl_in(scl), .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe), .irq_in(irq_w), .irq_out(irq_o),
        .irq_oe_out(irq_oe), .host_dir_in(host_dir), .battery_sense_input_in(batt), .shutdown_input_in(shut),
        .host_io_auto_dir_out(auto_dir), .host_io_card_to_host_out(c2h), .slot1_reg_en_out(s1_reg),
        .slot1_volt_sel_out(s1_volt), .slot1_state_out(s1_st), .slot1_pulldown_out(s1_pd),
        .slot2_reg_en_out(s2_reg), .slot2_volt_sel_out(s2_volt), .slot2_state_out(s2_st),
        .slot2_pulldown_out(s2_pd), .shutdown_input_pullup_en_out(pu), .shutdown_input_pulldown_en_out(pd),
        .bsi_level_sel_out(thresh), .clk_src_ext_out(clk_ext));
    smx_host_model smx_host_model_i (.clock_in(clock_in), .sda_in(sda_w), .scl_out(scl), .sda_low_out(sda_low));
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            errors++;
            summarize();
        end
    end
    task automatic chk_bit(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic ok;
        smx_host_model_i.write_reg(8'h78, idx, d, ok);
        chk_bit("write ack", 1'b1, ok);
    endtask
    task automatic chk_reg(input logic [7:0] idx, input logic [7:0] e);
        logic [7:0] g;
        smx_host_model_i.read_reg(idx, g);
        chk_byte($sformatf("reg %h", idx), e, g);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    // strap held low through reset so the address is 0x78
    task automatic do_reset();
        resetn_in <= 1'b0;
        strap_low <= 1'b1;
        settle(3);
        resetn_in <= 1'b1;
        settle(20);
        strap_low <= 1'b0;
    endtask
    // old detection settled false, then input driven true under the new control byte
    task automatic det(input logic [7:0] dev, input logic sd, input logic lvl, input logic [7:0] sim_e, input logic irq_e);
        logic [7:0] st;
        if (sd) shut <= ~lvl;
        else batt <= ~lvl;
        settle(300);
        wr(REG_DEV_CTRL, dev);
        wr(REG_SIM_CTRL, 8'hdd);
        smx_host_model_i.read_reg(REG_STATUS, st);
        if (sd) shut <= lvl;
        else batt <= lvl;
        settle(300);
        chk_bit("irq pin", irq_e, irq_oe);
        chk_reg(REG_SIM_CTRL, sim_e);
        smx_host_model_i.read_reg(REG_STATUS, st);
        chk_bit("status flag", irq_e, sd ? st[ST_SDN] : st[ST_BSI]);
        chk_bit("irq after status read", 1'b0, irq_oe);
    endtask
    initial begin
        logic ok;
        do_reset();
        chk_byte("pins after reset", 8'h26, {s1_reg, s1_volt, s1_pd, s2_reg, s2_volt, s2_pd, pu, pd});
        chk_byte("state after reset", 8'h00, {irq_oe, clk_ext, s1_st, s2_st, 2'b00});
        for (int i = 0; i < 7; i++) chk_reg(ri[i], rv[i]);
        wr(8'h3f, 8'h5a);
        chk_reg(8'h3f, 8'h00);
        smx_host_model_i.write_reg(8'h7a, REG_DEV_CTRL, 8'h01, ok);
        chk_bit("foreign address ack", 1'b0, ok);
        chk_reg(REG_DEV_CTRL, 8'h00);
        wr(REG_GP, 8'hff);
        chk_reg(REG_GP, 8'h03);
        chk_byte("pull pins", 8'h01, {6'h00, pu, pd});
        wr(REG_GP, 8'h00);
        chk_byte("pull pins", 8'h02, {6'h00, pu, pd});
        for (int m = 0; m < 8; m++) begin
            wr(REG_DEV_CTRL, {6'h00, m[1], m[0]});
            host_dir <= m[2];
            settle(10);
            chk_bit("auto direction", ~m[0], auto_dir);
            if (m[0]) chk_bit("card to host", m[2] ^ m[1], c2h);
        end
        wr(REG_DEV_CTRL, 8'h08);
        chk_bit("battery level select", 1'b1, thresh);
        wr(REG_CLK_CTRL, 8'h80);
        chk_bit("external clock", 1'b1, clk_ext);
        wr(REG_SIM_CTRL, 8'h00); // slot 1 at 1.8V, both interfaces off
        wr(REG_SIM_CTRL, 8'h01); // regulator before state bits
        wr(REG_SIM_CTRL, 8'h0d);
        chk_byte("slot1 pins", 8'h16, {3'h0, s1_reg, s1_volt, s1_st, s1_pd});
        wr(REG_SIM_CTRL, 8'h00); // silent card: power down, retry at 2.95V
        wr(REG_SIM_CTRL, 8'h0f);
        chk_byte("slot1 pins", 8'h1e, {3'h0, s1_reg, s1_volt, s1_st, s1_pd});
        det(8'h04, 1'b0, 1'b1, 8'h00, 1'b1);
        det(8'h10, 1'b0, 1'b1, 8'hdd, 1'b0);
        det(8'h20, 1'b1, 1'b0, 8'h0d, 1'b1);
        det(8'he0, 1'b1, 1'b1, 8'hdd, 1'b1);
        det(8'h00, 1'b1, 1'b0, 8'h0d, 1'b0);
        wr(REG_BATTERY_SENSE_DEBOUNCED, 8'h07);
        det(8'h14, 1'b0, 1'b1, 8'hdd, 1'b1);
        batt <= 1'b0;
        settle(300);
        batt <= 1'b1;
        settle(300);
        chk_bit("irq pending", 1'b1, irq_oe);
        do_reset();
        chk_bit("irq after reset", 1'b0, irq_oe);
        for (int i = 0; i < 7; i++) chk_reg(ri[i], rv[i]);
        summarize();
    end
endmodule
